// ===== include/pss_pkg.sv
// constants, types and burst arithmetic shared by the burst sram design
package pss_pkg;

    localparam int ADDR_W = 19;
    localparam int BEAT_W = 2;
    localparam int LANES = 4;
    localparam int DATA_W = 8;
    localparam int LANE_W = DATA_W + 1;
    localparam int WORD_W = LANES * LANE_W;
    localparam int LANE_A = 0;
    localparam int LANE_B = 1;
    localparam int LANE_C = 2;
    localparam int LANE_D = 3;
    localparam logic MODE_INTERLEAVED = 1'h1;
    localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;
    localparam logic [LANES-1:0] BWS_NONE = 4'hF;

    typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} pss_op_t;

    // low address bits of a beat within a burst
    function automatic logic [BEAT_W-1:0] burst_low(
        input logic [BEAT_W-1:0] start,
        input logic [BEAT_W-1:0] beat,
        input logic interleaved
    );
        if (interleaved == MODE_INTERLEAVED)
            burst_low = start ^ beat;
        else
            burst_low = start + beat;
    endfunction : burst_low

endpackage : pss_pkg

// ===== hw/pss_burst_ctr.sv
// two-bit burst counter with linear or interleaved order
`timescale 1ns/1ps
module pss_burst_ctr (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic advance,
    input wire logic [pss_pkg::BEAT_W-1:0] startLow,
    input wire logic interleaved,
    output logic [pss_pkg::BEAT_W-1:0] beatAddr
);
    import pss_pkg::*;

    logic [BEAT_W-1:0] start;
    logic [BEAT_W-1:0] beat;
    logic [BEAT_W-1:0] next_beat;

    // the counter simply overflows, which gives the wrap in both orders
    assign next_beat = beat + BEAT_STEP; // R17

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            start <= BEAT_FIRST;
            beat <= BEAT_FIRST;
        end
        else if (load)
        begin
            start <= startLow;
            beat <= BEAT_FIRST;
        end
        else if (advance)
        begin
            beat <= next_beat; // R16
        end
    end

    assign beatAddr = burst_low(start, beat, interleaved); // R26

endmodule : pss_burst_ctr

// ===== hw/pss_burst_sram.sv
// pipelined burst sram core with byte writes, parity lanes and sleep
`timescale 1ns/1ps
// Behaviour
// R1: address captured at edge selects one word
// R2: low byte select writes its lane only
// R3: parity bit follows its lane's byte select
// R4: host drives write enable low to write
// R5: advance steps counter, load takes new address
// R6: host loads new address after deselect
// R7: clock enable high freezes all state; sleepDly, asleep and dataOe still update
// R8: clock enable only stretches, never deselects
// R9: select needs first, third low, second high
// R10: output enable high turns data pins off
// R11: no drive in write data, deselect phases
// R12: load with selects and write high reads
// R13: read word leaves output register next edge
// R14: new command accepted every cycle
// R15: deselect floats pins after the next edge
// R16: burst of four steps two low bits
// R17: counter wraps after its last state
// R18: mode high interleaved, low linear
// R19: mode defaults interleaved, held constant
// R20: advance ignores selects and write enable
// R21: access type latched for whole burst
// R22: load with selects and write low writes
// R23: write data taken two edges after command
// R24: host gives byte selects every write beat
// R25: comes up deselected with pins off
// R26: linear adds beat, interleaved xors beat
// R27: sleep holds array contents, ignores commands; only loads are ignored here, an open burst still advances while asleep
module pss_burst_sram #(
    parameter int ADDR_W = pss_pkg::ADDR_W,
    parameter logic MODE_DEFAULT = pss_pkg::MODE_INTERLEAVED
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic clock_en_n,
    input wire logic chip_sel_first_n,
    input wire logic chip_sel_second,
    input wire logic chip_sel_third_n,
    input wire logic advance_load,
    input wire logic writeEn_n,
    input wire logic byte_write_sel_a_n,
    input wire logic byte_write_sel_b_n,
    input wire logic byte_write_sel_c_n,
    input wire logic byte_write_sel_d_n,
    input wire logic outEn_n,
    input wire logic burstMode,
    input wire logic sleep_req,
    input wire logic [pss_pkg::DATA_W-1:0] data_lane_a_in,
    input wire logic [pss_pkg::DATA_W-1:0] data_lane_b_in,
    input wire logic [pss_pkg::DATA_W-1:0] data_lane_c_in,
    input wire logic [pss_pkg::DATA_W-1:0] data_lane_d_in,
    input wire logic parity_lane_a_in,
    input wire logic parity_lane_b_in,
    input wire logic parity_lane_c_in,
    input wire logic parity_lane_d_in,
    output logic [pss_pkg::DATA_W-1:0] data_lane_a_out,
    output logic [pss_pkg::DATA_W-1:0] data_lane_b_out,
    output logic [pss_pkg::DATA_W-1:0] data_lane_c_out,
    output logic [pss_pkg::DATA_W-1:0] data_lane_d_out,
    output logic parity_lane_a_out,
    output logic parity_lane_b_out,
    output logic parity_lane_c_out,
    output logic parity_lane_d_out,
    output logic data_lane_a_oe,
    output logic data_lane_b_oe,
    output logic data_lane_c_oe,
    output logic data_lane_d_oe,
    output logic parity_lane_a_oe,
    output logic parity_lane_b_oe,
    output logic parity_lane_c_oe,
    output logic parity_lane_d_oe
);
    import pss_pkg::*;

    localparam int DEPTH = 1 << ADDR_W;

    // ----------------------------------------------------------------
    // storage and helpers
    // ----------------------------------------------------------------
    logic [WORD_W-1:0] mem [0:DEPTH-1];

    function automatic logic [WORD_W-1:0] merge_bytes(
        input logic [WORD_W-1:0] old,
        input logic [WORD_W-1:0] din,
        input logic [LANES-1:0] bwsN
    );
        merge_bytes = old;
        for (int i = 0; i < LANES; i++)
        begin
            if (!bwsN[i])
                merge_bytes[i*LANE_W +: LANE_W] = din[i*LANE_W +: LANE_W]; // R2 R3
        end
    endfunction : merge_bytes

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    logic recog;
    logic selected;
    logic loadCmd;
    logic loadSel;
    logic advCmd;
    logic sleepDly;
    logic asleep;
    logic modeSel;
    pss_op_t burstOp;
    logic [ADDR_W-1:BEAT_W] baseHi;
    logic [BEAT_W-1:0] lowBits;
    logic [ADDR_W-1:0] curAddr;
    logic [LANES-1:0] bwsIn;
    logic [WORD_W-1:0] busIn;

    assign recog = !clock_en_n; // R7
    // sleep blocks new selects; pending data beats still drain
    assign selected = !chip_sel_first_n && chip_sel_second
        && !chip_sel_third_n && !asleep; // R9 R27
    assign loadCmd = recog && !advance_load; // R5
    assign loadSel = loadCmd && selected;
    // advance never looks at selects or write enable
    assign advCmd = recog && advance_load && (burstOp != OP_IDLE); // R5 R20
    assign curAddr = {baseHi, lowBits}; // R1
    assign bwsIn = {byte_write_sel_d_n, byte_write_sel_c_n,
        byte_write_sel_b_n, byte_write_sel_a_n};
    assign busIn = {parity_lane_d_in, data_lane_d_in, parity_lane_c_in, data_lane_c_in,
        parity_lane_b_in, data_lane_b_in, parity_lane_a_in, data_lane_a_in};

    // mode is a strap: a floating pin is modelled by MODE_DEFAULT at reset
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            modeSel <= MODE_DEFAULT; // R19
        else if (recog && burstOp == OP_IDLE)
            modeSel <= burstMode; // R7 R18
    end

    // two clocks to enter or leave sleep
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sleepDly <= 1'h0;
            asleep <= 1'h0;
        end
        else
        begin
            sleepDly <= sleep_req;
            asleep <= sleepDly; // R27
        end
    end

    // ----------------------------------------------------------------
    // burst state
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            burstOp <= OP_IDLE; // R25
        else if (loadCmd)
        begin
            case ({selected, writeEn_n})
                2'h3: burstOp <= OP_READ; // R12
                2'h2: burstOp <= OP_WRITE; // R22
                default: burstOp <= OP_IDLE; // R9
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            baseHi <= '0;
        else if (loadSel)
            baseHi <= addr[ADDR_W-1:BEAT_W]; // R1
    end

    pss_burst_ctr u_ctr (
        .mclk(mclk),
        .rst_n(rst_n),
        .load(loadSel),
        .advance(advCmd),
        .startLow(addr[BEAT_W-1:0]),
        .interleaved(modeSel),
        .beatAddr(lowBits)
    );

    // ----------------------------------------------------------------
    // data pipeline
    // ----------------------------------------------------------------
    pss_op_t s1Op;
    pss_op_t s2Op;
    pss_op_t next_s1Op;
    logic [LANES-1:0] s1Bws;
    logic [LANES-1:0] s2Bws;
    logic [ADDR_W-1:0] s2Addr;
    logic [WORD_W-1:0] readWord;
    logic readPhase;
    logic dataOe;
    logic next_readPhase;

    // the access type comes from the burst, not the pins, on an advance
    always_comb
    begin
        next_s1Op = OP_IDLE;
        if (loadCmd && selected)
            next_s1Op = writeEn_n ? OP_READ : OP_WRITE; // R12 R22
        else if (advCmd)
            next_s1Op = burstOp; // R21
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s1Op <= OP_IDLE;
            s2Op <= OP_IDLE;
            s1Bws <= BWS_NONE;
            s2Bws <= BWS_NONE;
            s2Addr <= '0;
        end
        else if (recog)
        begin
            s1Op <= next_s1Op; // R14
            s1Bws <= bwsIn; // R2
            s2Op <= s1Op;
            s2Bws <= s1Bws;
            s2Addr <= curAddr;
        end
    end

    // write data lands on the second recognized edge after its command
    always_ff @(posedge mclk)
    begin
        if (recog && s2Op == OP_WRITE)
            mem[s2Addr] <= merge_bytes(mem[s2Addr], busIn, s2Bws); // R2 R3 R23
    end

    // forward a write landing at the same edge so back-to-back stays coherent
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            readWord <= '0;
        else if (recog && s1Op == OP_READ)
        begin
            if (s2Op == OP_WRITE && s2Addr == curAddr)
                readWord <= merge_bytes(mem[curAddr], busIn, s2Bws); // R13
            else
                readWord <= mem[curAddr]; // R13
        end
    end

    assign next_readPhase = recog ? (s1Op == OP_READ) : readPhase; // R8 R15

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            readPhase <= 1'h0; // R25
        else
            readPhase <= next_readPhase; // R11
    end

    // output enable is sampled, so it acts one edge late
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            dataOe <= 1'h0; // R25
        else
            dataOe <= next_readPhase && !outEn_n && !asleep; // R10 R11
    end

    // ----------------------------------------------------------------
    // pins
    // ----------------------------------------------------------------
    assign data_lane_a_out = readWord[LANE_A*LANE_W +: DATA_W];
    assign data_lane_b_out = readWord[LANE_B*LANE_W +: DATA_W];
    assign data_lane_c_out = readWord[LANE_C*LANE_W +: DATA_W];
    assign data_lane_d_out = readWord[LANE_D*LANE_W +: DATA_W];
    assign parity_lane_a_out = readWord[LANE_A*LANE_W + DATA_W];
    assign parity_lane_b_out = readWord[LANE_B*LANE_W + DATA_W];
    assign parity_lane_c_out = readWord[LANE_C*LANE_W + DATA_W];
    assign parity_lane_d_out = readWord[LANE_D*LANE_W + DATA_W];
    assign data_lane_a_oe = dataOe;
    assign data_lane_b_oe = dataOe;
    assign data_lane_c_oe = dataOe;
    assign data_lane_d_oe = dataOe;
    assign parity_lane_a_oe = dataOe;
    assign parity_lane_b_oe = dataOe;
    assign parity_lane_c_oe = dataOe;
    assign parity_lane_d_oe = dataOe;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    logic [LANE_W-1:0] laneAOld;
    assign laneAOld = mem[s2Addr][LANE_A*LANE_W +: LANE_W];

    sequence rdIssue;
        !clock_en_n && !advance_load && selected && writeEn_n;
    endsequence

    sequence wrIssue;
        !clock_en_n && !advance_load && selected && !writeEn_n;
    endsequence

    sequence deselIssue;
        !clock_en_n && !advance_load && !selected;
    endsequence

    sequence advBeat;
        !clock_en_n && advance_load;
    endsequence

    read_drive_a: assert property ( // R13
        rdIssue ##1 (!clock_en_n && !outEn_n && !asleep) |=> dataOe)
        else $error("read data not driven one edge after command");

    write_float_a: assert property ( // R11
        wrIssue ##1 !clock_en_n |=> !dataOe)
        else $error("pins driven in write data phase");

    desel_float_a: assert property ( // R15
        deselIssue ##1 !clock_en_n |=> !dataOe)
        else $error("pins driven after pipelined deselect");

    oe_mask_a: assert property ( // R10
        outEn_n |=> !dataOe)
        else $error("pins driven with output enable high");

    stall_hold_a: assert property ( // R7
        clock_en_n |=> $stable(readWord) && $stable(burstOp) && $stable(s1Op)
            && $stable(lowBits))
        else $error("state changed while clock enable high");

    burst_wrap_a: assert property ( // R17
        (!clock_en_n && !advance_load && selected) ##1 advBeat [*4]
            |=> lowBits == $past(addr[BEAT_W-1:0], 5))
        else $error("burst counter did not wrap to start");

    interleave_a: assert property ( // R18
        (loadSel && modeSel == MODE_INTERLEAVED && burstMode == MODE_INTERLEAVED)
            ##1 advBeat |=> lowBits == ($past(addr[BEAT_W-1:0], 2) ^ BEAT_STEP))
        else $error("interleaved second beat wrong");

    burst_keep_a: assert property ( // R21
        advCmd |=> burstOp == $past(burstOp) && s1Op == $past(burstOp))
        else $error("access type changed inside burst");

    byte_mask_a: assert property ( // R2
        (!clock_en_n && s2Op == OP_WRITE && s2Bws[LANE_A])
            |=> mem[$past(s2Addr)][LANE_A*LANE_W +: LANE_W] == $past(laneAOld))
        else $error("unselected lane written");

    sleep_idle_a: assert property ( // R27
        (asleep && loadCmd) |=> burstOp == OP_IDLE)
        else $error("command taken while asleep");

    reset_desel_a: assert property ( // R25
        $rose(rst_n) |-> !dataOe && burstOp == OP_IDLE && s1Op == OP_IDLE)
        else $error("not deselected after reset");

endmodule : pss_burst_sram

// ===== test/pss_host_pins.sv
// host side pin model: resolves the shared data and parity pins
`timescale 1ns/1ps
module pss_host_pins (
    input wire logic mclk,
    input wire logic [pss_pkg::WORD_W-1:0] hWord,
    input wire logic hDrive,
    input wire logic [pss_pkg::WORD_W-1:0] dev,
    input wire logic devDrive,
    output logic [pss_pkg::WORD_W-1:0] pin,
    output logic clash
);
    import pss_pkg::*;
    logic [WORD_W-1:0] last;

    // released pins show the inverse of the last level, never a stale copy
    always_ff @(posedge mclk)
        last <= pin;

    always_comb
    begin
        if (hDrive)
            pin = hWord;
        else if (devDrive)
            pin = dev;
        else
            pin = ~last;
    end

    assign clash = hDrive & devDrive;
endmodule : pss_host_pins

// ===== test/pss_burst_sram_tb.sv
// self-checking bench for the pipelined burst sram core
`timescale 1ns/1ps
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin nMismatch++; \
    $display("wrong value at %0t got %h expected %h", $time, (g), (e)); end end
module pss_burst_sram_tb;
    import pss_pkg::*;
    localparam int AW = 8;
    localparam int LIMIT = 2000;
    logic mclk, rst_n, clkEnN, advLoad, wrEnN, outEnN, mode, sleep, hDrive, clash;
    logic edgeOk, stallEdge, bMode, bWr;
    logic [1:0] bBeat;
    logic [2:0] sel;
    logic [3:0] bwsN;
    logic [7:0] oe;
    logic [15:0] rnd;
    logic [AW-1:0] addr, bBase;
    logic [WORD_W-1:0] hWord, pin, dev, rw, expW;
    logic [WORD_W+7:0] prevOut;
    logic [WORD_W-1:0] mem [0:(1<<AW)-1];
    logic [WORD_W-1:0] wrData [0:1];
    logic wrOn [0:1];
    logic [WORD_W-1:0] expQ [$];
    int dueQ [$];
    int nMismatch, cmpCount, cycles, nEdge, due;

    pss_burst_sram #(.ADDR_W(AW), .MODE_DEFAULT(MODE_INTERLEAVED)) DUT (
        .mclk(mclk), .rst_n(rst_n), .addr(addr), .clock_en_n(clkEnN), .outEn_n(outEnN),
        .chip_sel_first_n(sel[0]), .chip_sel_second(sel[1]), .chip_sel_third_n(sel[2]),
        .advance_load(advLoad), .writeEn_n(wrEnN), .burstMode(mode), .sleep_req(sleep),
        .byte_write_sel_a_n(bwsN[0]), .byte_write_sel_b_n(bwsN[1]),
        .byte_write_sel_c_n(bwsN[2]), .byte_write_sel_d_n(bwsN[3]),
        .data_lane_a_in(pin[7:0]), .data_lane_b_in(pin[16:9]),
        .data_lane_c_in(pin[25:18]), .data_lane_d_in(pin[34:27]),
        .parity_lane_a_in(pin[8]), .parity_lane_b_in(pin[17]),
        .parity_lane_c_in(pin[26]), .parity_lane_d_in(pin[35]),
        .data_lane_a_out(dev[7:0]), .data_lane_b_out(dev[16:9]),
        .data_lane_c_out(dev[25:18]), .data_lane_d_out(dev[34:27]),
        .parity_lane_a_out(dev[8]), .parity_lane_b_out(dev[17]),
        .parity_lane_c_out(dev[26]), .parity_lane_d_out(dev[35]),
        .data_lane_a_oe(oe[0]), .data_lane_b_oe(oe[1]), .data_lane_c_oe(oe[2]),
        .data_lane_d_oe(oe[3]), .parity_lane_a_oe(oe[4]), .parity_lane_b_oe(oe[5]),
        .parity_lane_c_oe(oe[6]), .parity_lane_d_oe(oe[7])
    );
    pss_host_pins HOST (.mclk(mclk), .hWord(hWord), .hDrive(hDrive), .dev(dev),
        .devDrive(|oe), .pin(pin), .clash(clash));

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // ----------------------------------------
    // host side bus tasks
    // ----------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic roll;
        repeat (3)
        begin
            rnd = lfsr(rnd);
            rw = {rw[19:0], rnd};
        end
    endtask : roll

    function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] o, n,
        input logic [3:0] b);
        merge = o;
        for (int i = 0; i < LANES; i++)
            if (!b[i])
                merge[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
    endfunction : merge

    task automatic noteRead(input logic [WORD_W-1:0] w);
        expQ.push_back(w);
        dueQ.push_back(nEdge + 2);
    endtask : noteRead

    // write data goes out two recognized edges after its command
    task automatic tick(input logic wr, input logic [WORD_W-1:0] w);
        if (!clkEnN)
        begin
            hDrive = wrOn[1];
            hWord = wrData[1];
            wrOn[1] = wrOn[0];
            wrData[1] = wrData[0];
            wrOn[0] = wr;
            wrData[0] = w;
        end
        @(posedge mclk);
        #1;
    endtask : tick

    task automatic load(input logic [AW-1:0] a, input logic wr, input logic [3:0] b);
        roll;
        clkEnN = 1'b0;
        sel = 3'b010;
        advLoad = 1'b0;
        wrEnN = ~wr;
        addr = a;
        bwsN = b;
        {bBase, bBeat, bMode, bWr} = {a, 2'h0, mode, wr};
        if (wr && !sleep)
            mem[a] = merge(mem[a], rw, b);
        else if (!wr && !outEnN && !sleep)
            noteRead(mem[a]);
        tick(wr && !sleep, rw);
    endtask : load

    task automatic step(input logic [3:0] b);
        logic [AW-1:0] a;
        roll;
        clkEnN = 1'b0;
        bBeat = bBeat + 2'h1;
        a = bBase;
        a[1:0] = bMode ? bBase[1:0] ^ bBeat : bBase[1:0] + bBeat;
        advLoad = 1'b1;
        {sel, wrEnN} = rw[35:32];
        addr = rw[AW+23:24];
        bwsN = b;
        if (bWr)
            mem[a] = merge(mem[a], rw, b);
        else
            noteRead(mem[a]);
        tick(bWr, rw);
    endtask : step

    // deselect with a write attempt at a live address now and then
    task automatic desel(input int k);
        roll;
        clkEnN = 1'b0;
        sel = 3'b010 ^ (3'h1 << k);
        {advLoad, wrEnN, bwsN} = {1'b0, rw[0], rw[7:4]};
        addr = 8'h21;
        tick(1'b0, rw);
    endtask : desel

    task automatic stall;
        roll;
        clkEnN = 1'b1;
        {sel, advLoad, wrEnN, bwsN} = rw[8:0];
        addr = rw[AW+15:16];
        tick(1'b0, rw);
    endtask : stall

    task automatic burst(input logic [AW-1:0] a, input logic wr);
        load(a, wr, rw[3:0]);
        repeat (4) step(rw[7:4]);
        stall;
        step(rw[3:0]);
        desel(2);
    endtask : burst

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
        if (nMismatch == 0 && cmpCount > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    // each cycle after a recognized edge with pins driven carries one read beat
    always @(posedge mclk)
    begin
        edgeOk = rst_n && !clkEnN;
        stallEdge = rst_n && clkEnN;
        nEdge += edgeOk;
        cycles++;
        if (cycles == LIMIT)
        begin
            nMismatch++;
            results;
        end
        #2;
        `CHK(clash, 1'b0)
        if (stallEdge)
            `CHK({oe, dev}, prevOut)
        else if (edgeOk && oe !== 8'h00)
        begin
            expW = expQ.size() > 0 ? expQ.pop_front() : ~dev;
            due = dueQ.size() > 0 ? dueQ.pop_front() : -1;
            `CHK({oe, dev}, {8'hFF, expW})
            `CHK(nEdge, due)
        end
        prevOut = {oe, dev};
    end

    initial
    begin
        {rst_n, clkEnN, advLoad, outEnN, sleep, hDrive, wrEnN, mode} = 8'h03;
        {sel, bwsN, addr, bBase, bBeat, bMode, bWr} = {3'b011, BWS_NONE, 20'h00000};
        {hWord, rw, rnd} = {72'h0, 16'h004A};
        wrOn = '{1'b0, 1'b0};
        wrData = '{'0, '0};
        {nMismatch, cmpCount, cycles, nEdge} = '0;
        repeat (20) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        `CHK(oe, 8'h00)
        $display("test reset done");
        load(8'h10, 1'b1, 4'h0);
        for (int p = 0; p < 16; p++)
        begin
            load(8'h10, 1'b1, p[3:0]);
            load(8'h10, 1'b0, BWS_NONE);
        end
        for (int a = 32; a < 36; a++)
            load(a[AW-1:0], 1'b1, 4'h0);
        desel(0);
        $display("test byte lanes done");
        mode = 1'b0;
        desel(1);
        burst(8'h22, 1'b1);
        for (int a = 32; a < 36; a++)
            load(a[AW-1:0], 1'b0, BWS_NONE);
        desel(0);
        $display("test linear burst write done");
        mode = 1'b1;
        desel(1);
        burst(8'h21, 1'b0);
        $display("test interleaved burst read done");
        for (int k = 0; k < 9; k++)
            desel(k % 3);
        load(8'h21, 1'b0, BWS_NONE);
        desel(0);
        $display("test chip selects done");
        outEnN = 1'b1;
        load(8'h22, 1'b0, BWS_NONE);
        desel(0);
        desel(1);
        outEnN = 1'b0;
        load(8'h23, 1'b0, BWS_NONE);
        desel(2);
        $display("test output enable done");
        sleep = 1'b1;
        repeat (3) desel(0);
        load(8'h21, 1'b1, 4'h0);
        load(8'h22, 1'b0, BWS_NONE);
        sleep = 1'b0;
        repeat (3) desel(0);
        load(8'h21, 1'b0, BWS_NONE);
        load(8'h22, 1'b0, BWS_NONE);
        repeat (2) desel(0);
        `CHK(expQ.size(), 0)
        $display("test sleep done");
        results;
    end
endmodule : pss_burst_sram_tb
